// *** inc/reg_fault_pkg.sv ***
// Purpose: constants and carriers for the regulator fault supervisor
// Assumes: clk_sys at 40 MHz, comparator results arrive as raw pins
// Notes: all timing figures are kept in their own unit and turned into cycles here
//
// How it works
// - a switch-node negative excursion lasting past 157 ns sets a diode fault latch that holds the converter off.
// - the diode fault latch clears only on a supply dropout or a fall of the combined enable.
// - a thermal trip stops pre-regulator switching, is not latched, and switching resumes when it ends.
// - a thermal trip never pulls the reset output directly; only rail undervoltage, enables low, pump low, internal rail low or supply dropout do.
// - the reset output stays low for the programmed delay counted after both rails pass their upper thresholds.
// - the reset output goes low at once on either rail under threshold, enables low, pump low or internal rail low.
// - when disabled or unsupplied the reset output stays low until the 3.3 Internal_rail is below 1.0 V.
// - the reset output is open drain: the block only pulls low, the pull-up is outside.
// - a short on the tracked remote 5 V output disables that output only, the other rails stay on.
// - a pump supply fault disables the charge pump.
// - the device is enabled by the OR of logic and ignition enables and disabled only when both are low.
// - the ignition status output follows the sensed ignition enable input.
// - a 10 ms soft start begins only on a rising enable with no thermal trip and both rails under threshold.
// - a switch-node peak current short latches the converter off until supply dropout or disable and re-enable.
package reg_fault_pkg;
	localparam int unsigned CLK_HZ           = 40000000;
	localparam int unsigned CLK_PERIOD_PS    = 25000;
	localparam int unsigned DIODE_FILTER_PS  = 157000;
	// least time, rounded up
	localparam int unsigned DIODE_FILTER_CYC =
		(DIODE_FILTER_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SOFT_START_MS    = 10;
	localparam int unsigned SOFT_START_CYC   = SOFT_START_MS * (CLK_HZ / 1000);
	// default delay for a 10 nF capacitor: 92.3e3 * 10e-9 s = 923 us
	localparam int unsigned RESET_DELAY_US   = 923;
	localparam int unsigned RESET_DELAY_CYC  = RESET_DELAY_US * (CLK_HZ / 1000000);
	localparam int unsigned SYNC_STAGES      = 2;
	localparam int unsigned NUM_SENSE        = 12;

	// raw comparator and pin levels, all asynchronous to clk_sys
	typedef struct packed {
		logic logicEnable;      // logic_enable_in
		logic ignitionEnable;   // ignition_enable_in
		logic supplyOk;         // supply_input above its UVLO
		logic preregOk;         // preregulator_output above upper UVLO
		logic aux3v3Ok;         // aux_3v3_rail above upper UVLO
		logic aux3v3AboveOneV;  // aux_3v3_rail above 1.0 V
		logic pumpOk;           // pump_supply_node high enough
		logic pumpFault;        // pump_supply_node fault
		logic railOk;           // internal_rail good
		logic thermalTrip;      // thermal_trip comparator
		logic switchNodeNeg;    // switch_node below negative threshold
		logic peakCurrent;      // switch current above peak limit
	} sense_s;

	typedef struct packed {
		logic remoteShort;      // tracked_remote_5v_out short sensed
	} remote_s;
endpackage

// *** rtl/regulator_fault_supervisor.sv ***
// Purpose: fault latching, enable logic and reset supervision of a multi-rail regulator
// Assumes: analogue comparators appear as digital levels from another domain
// Notes: the open-drain reset pin is split into a drive-low level and an enable
`timescale 1ns/100ps
module regulator_fault_supervisor
	import reg_fault_pkg::*;
#(
	parameter int unsigned SOFT_START_CYCLES  = SOFT_START_CYC,
	parameter int unsigned RESET_DELAY_CYCLES = RESET_DELAY_CYC
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// comparator and pin levels
	input  wire sense_s   senseIn,
	input  wire remote_s  remoteIn,
	input  wire logic     supervisorResetIn,
	// open-drain reset output
	output logic          supervisorResetOut,
	output logic          supervisorResetOe_n,
	// rail and converter controls
	output logic          switcherEnable,
	output logic          softStartActive,
	output logic          chargePumpEnable,
	output logic          remote5vEnable,
	output logic          local5vEnable,
	output logic          aux3v3Enable,
	// status
	output logic          ignitionStatusOut,
	output logic          diodeFaultLatched,
	output logic          shortFaultLatched
);
	typedef enum logic [1:0] {RST_HOLD, RST_DELAY, RST_RELEASED} rst_state_e;

	// two-stage synchronisers, one generate per sense bit, the remote short bit in its own block
	logic [NUM_SENSE-1:0] senseRaw;
	logic [NUM_SENSE-1:0] syncA_r;
	logic [NUM_SENSE-1:0] syncB_r;
	logic                 remA_r;
	logic                 remB_r;
	sense_s               s;

	assign senseRaw = senseIn;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SENSE; gi++) begin : g_sync
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					syncA_r[gi] <= 1'b0;
					syncB_r[gi] <= 1'b0;
				end else begin
					syncA_r[gi] <= senseRaw[gi];
					syncB_r[gi] <= syncA_r[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			remA_r <= 1'b0;
			remB_r <= 1'b0;
		end else begin
			remA_r <= remoteIn.remoteShort;
			remB_r <= remA_r;
		end
	end

	assign s = sense_s'(syncB_r);

	// combined enable and its edges
	logic enabled;
	logic enabledPrev_r;
	logic enabledPrev_nxt;
	logic enRise;
	logic enFall;
	logic supplyPrev_r;
	logic supplyPrev_nxt;
	logic supplyFall;

	assign enabled        = s.logicEnable | s.ignitionEnable;
	assign enRise         = enabled & ~enabledPrev_r;
	assign enFall         = ~enabled & enabledPrev_r;
	assign supplyFall     = ~s.supplyOk & supplyPrev_r;
	assign enabledPrev_nxt = enabled;
	assign supplyPrev_nxt  = s.supplyOk;

	// diode fault filter and latches
	localparam int unsigned FW = $clog2(DIODE_FILTER_CYC + 1);
	logic [FW-1:0] negCount_r;
	logic [FW-1:0] negCount_nxt;
	logic          diodeFault_r;
	logic          diodeFault_nxt;
	logic          shortFault_r;
	logic          shortFault_nxt;
	logic          latchClear;

	// a cycle of supply or of the combined enable both clear
	assign latchClear = supplyFall | enFall | ~s.supplyOk;

	always_comb begin
		negCount_nxt   = negCount_r;
		diodeFault_nxt = diodeFault_r;
		shortFault_nxt = shortFault_r;
		if (!s.switchNodeNeg) begin
			negCount_nxt = '0;
		end else if (negCount_r != FW'(DIODE_FILTER_CYC)) begin
			negCount_nxt = negCount_r + FW'(1);
		end
		if (latchClear) begin
			diodeFault_nxt = 1'b0;
			shortFault_nxt = 1'b0;
		end
		// a set in the same cycle as a clear wins
		if (s.switchNodeNeg && negCount_r == FW'(DIODE_FILTER_CYC) && s.supplyOk) begin
			diodeFault_nxt = 1'b1;
		end
		if (s.peakCurrent && s.supplyOk) begin
			shortFault_nxt = 1'b1;
		end
	end

	// soft start
	localparam int unsigned SW = $clog2(SOFT_START_CYCLES + 1);
	logic [SW-1:0] ssCount_r;
	logic [SW-1:0] ssCount_nxt;
	logic          ssArmed_r;
	logic          ssArmed_nxt;

	always_comb begin
		ssCount_nxt = ssCount_r;
		ssArmed_nxt = ssArmed_r;
		if (!enabled) begin
			ssArmed_nxt = 1'b0;
			ssCount_nxt = '0;
		end else if (enRise && !s.thermalTrip && !s.aux3v3Ok && !s.preregOk) begin
			ssArmed_nxt = 1'b1;
			ssCount_nxt = SW'(SOFT_START_CYCLES);
		end else if (ssCount_r != '0) begin
			ssCount_nxt = ssCount_r - SW'(1);
		end
	end

	// reset supervisor
	localparam int unsigned RW = $clog2(RESET_DELAY_CYCLES + 1);
	rst_state_e    rstState_r;
	rst_state_e    rstState_nxt;
	logic [RW-1:0] rstCount_r;
	logic [RW-1:0] rstCount_nxt;
	logic          forceLow;
	logic          disabledHold;

	// thermal trip is not in this list: it only acts through the rails
	assign forceLow = ~s.aux3v3Ok | ~s.preregOk | ~enabled
		| ~s.pumpOk | ~s.railOk;
	// while disabled, hold low until the 3.3 Internal_rail is under 1.0 V
	assign disabledHold = (~enabled | ~s.supplyOk) & s.aux3v3AboveOneV;

	always_comb begin
		rstState_nxt = rstState_r;
		rstCount_nxt = rstCount_r;
		case (rstState_r)
			RST_HOLD: begin
				if (!forceLow && !disabledHold) begin
					rstState_nxt = RST_DELAY;
					rstCount_nxt = RW'(RESET_DELAY_CYCLES);
				end
			end
			RST_DELAY: begin
				if (forceLow || disabledHold) begin
					rstState_nxt = RST_HOLD;
				end else if (rstCount_r <= RW'(1)) begin
					rstState_nxt = RST_RELEASED;
					rstCount_nxt = '0;
				end else begin
					rstCount_nxt = rstCount_r - RW'(1);
				end
			end
			RST_RELEASED: begin
				if (forceLow || disabledHold) begin
					rstState_nxt = RST_HOLD;
				end
			end
			default: begin
				rstState_nxt = RST_HOLD;
			end
		endcase
	end

	// converter controls
	logic runOk;
	logic swEn_nxt;
	logic cpEn_nxt;
	logic rem5_nxt;
	logic loc5_nxt;
	logic aux33_nxt;
	logic ssAct_nxt;

	assign runOk = enabled & s.supplyOk & ~diodeFault_r & ~shortFault_r;

	always_comb begin
		swEn_nxt  = runOk & ~s.thermalTrip;
		cpEn_nxt  = runOk & ~s.pumpFault;
		rem5_nxt  = runOk & ~remB_r;
		loc5_nxt  = runOk;
		aux33_nxt = runOk;
		// soft start is status only, switching does not wait on the ramp
		ssAct_nxt = ssArmed_nxt & (ssCount_nxt != '0);
	end

	// status
	logic ignSt_nxt;

	always_comb begin
		ignSt_nxt = s.ignitionEnable;
	end

	// open-drain reset pin
	logic rstLevel_nxt;
	logic rstRelease_nxt;

	always_comb begin
		// the data level never leaves low, only the enable moves
		rstLevel_nxt   = 1'b0;
		rstRelease_nxt = (rstState_nxt == RST_RELEASED);
	end

	// enable and supply edge memories
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			enabledPrev_r <= 1'b0;
			supplyPrev_r  <= 1'b0;
		end else begin
			enabledPrev_r <= enabledPrev_nxt;
			supplyPrev_r  <= supplyPrev_nxt;
		end
	end

	// filter counts synced samples, so the window is one sample coarser than the limit
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			negCount_r   <= '0;
			diodeFault_r <= 1'b0;
			shortFault_r <= 1'b0;
		end else begin
			negCount_r   <= negCount_nxt;
			diodeFault_r <= diodeFault_nxt;
			shortFault_r <= shortFault_nxt;
		end
	end

	// soft start registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ssCount_r <= '0;
			ssArmed_r <= 1'b0;
		end else begin
			ssCount_r <= ssCount_nxt;
			ssArmed_r <= ssArmed_nxt;
		end
	end

	// a drop inside the delay window restarts the full count, never a partial one
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rstState_r <= RST_HOLD;
			rstCount_r <= '0;
		end else begin
			rstState_r <= rstState_nxt;
			rstCount_r <= rstCount_nxt;
		end
	end

	// controls come from flops, so a sync glitch never reaches a gate driver
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			switcherEnable   <= 1'b0;
			softStartActive  <= 1'b0;
			chargePumpEnable <= 1'b0;
			remote5vEnable   <= 1'b0;
			local5vEnable    <= 1'b0;
			aux3v3Enable     <= 1'b0;
		end else begin
			switcherEnable   <= swEn_nxt;
			softStartActive  <= ssAct_nxt;
			chargePumpEnable <= cpEn_nxt;
			remote5vEnable   <= rem5_nxt;
			local5vEnable    <= loc5_nxt;
			aux3v3Enable     <= aux33_nxt;
		end
	end

	// status flops
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ignitionStatusOut <= 1'b0;
			diodeFaultLatched <= 1'b0;
			shortFaultLatched <= 1'b0;
		end else begin
			ignitionStatusOut <= ignSt_nxt;
			diodeFaultLatched <= diodeFault_nxt;
			shortFaultLatched <= shortFault_nxt;
		end
	end

	// reset pin flops: pulled low during reset, released only from the released state
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			supervisorResetOut  <= 1'b0;
			supervisorResetOe_n <= 1'b0;
		end else begin
			supervisorResetOut  <= rstLevel_nxt;
			supervisorResetOe_n <= rstRelease_nxt;
		end
	end

	// pin readback unused: the pull-up level carries no state here
	logic unusedPin;
	assign unusedPin = supervisorResetIn;
endmodule // regulator_fault_supervisor

// *** sim/reset_pin_model.sv ***
// Purpose: far side of the open-drain reset line
// Assumes: pull-up on the host board
// Notes: released pin reads the pull-up level, never the last driven value
`timescale 1ns/100ps
module reset_pin_model (
	// from the supervisor
	input  wire logic resetOut,
	input  wire logic resetOe_n,
	// resolved pin
	output logic      pin
);
	assign pin = resetOe_n ? 1'b1 : resetOut;
endmodule // reset_pin_model

// *** sim/fault_sup_checker.sv ***
// Purpose: port-level checks of the supervisor
// Assumes: outputs follow inputs sampled three edges earlier
// Notes: counters replace long repetitions
`timescale 1ns/100ps
module fault_sup_checker
	import reg_fault_pkg::*;
#(
	parameter int unsigned RESET_DELAY_CYCLES = RESET_DELAY_CYC
) (
	input wire logic    clk_sys,
	input wire logic    reset_n,
	input wire sense_s  senseIn,
	input wire remote_s remoteIn,
	input wire logic    supervisorResetOe_n,
	input wire logic    switcherEnable,
	input wire logic    chargePumpEnable,
	input wire logic    remote5vEnable,
	input wire logic    ignitionStatusOut,
	input wire logic    diodeFaultLatched
);
	// wide enough for the delay plus latency, so the late bound stays reachable
	localparam int unsigned OW = $clog2(RESET_DELAY_CYCLES + 8);
	logic [2:0]    up;
	logic [OW-1:0] okCnt;
	logic [7:0] negCnt;
	logic       en;
	logic       ok;
	assign en = senseIn.logicEnable | senseIn.ignitionEnable;
	assign ok = en & senseIn.supplyOk & senseIn.preregOk & senseIn.aux3v3Ok
		& senseIn.pumpOk & senseIn.railOk;
	// saturating, so an idle run never wraps into a false match
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			up <= 3'h0;
			okCnt <= '0;
			negCnt <= 8'h00;
		end else begin
			up <= up + {2'h0, up != 3'h7};
			okCnt <= ok ? okCnt + OW'(okCnt != '1) : '0;
			negCnt <= senseIn.switchNodeNeg ? negCnt + {7'h00, negCnt != 8'hff} : 8'h00;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	AST_IGN_STATUS: assert property (up > 3'h3 |-> ignitionStatusOut == $past(senseIn.ignitionEnable, 3))
		else $error("ignition status does not follow input");
	AST_FORCE_LOW: assert property (up > 3'h3 && !$past(ok, 3) && $past(senseIn.supplyOk, 3) |-> !supervisorResetOe_n)
		else $error("reset not pulled low");
	AST_HOLD_REL: assert property (up > 3'h4 && supervisorResetOe_n && $past(ok, 2) |=> supervisorResetOe_n)
		else $error("reset dropped without a cause");
	AST_DELAY_MIN: assert property ($rose(supervisorResetOe_n) |-> okCnt >= OW'(RESET_DELAY_CYCLES))
		else $error("reset released early");
	AST_DELAY_MAX: assert property (okCnt == OW'(RESET_DELAY_CYCLES + 6) |-> supervisorResetOe_n)
		else $error("reset release late");
	AST_DIODE_SET: assert property (negCnt == 8'h0c && senseIn.supplyOk |-> diodeFaultLatched)
		else $error("diode fault not latched");
	AST_DIODE_HOLD: assert property (diodeFaultLatched && $past(ok, 2) && $past(ok, 3) |=> diodeFaultLatched)
		else $error("diode fault cleared early");
	AST_REMOTE: assert property (up > 3'h3 && $past(remoteIn.remoteShort, 3) |-> !remote5vEnable)
		else $error("remote output not isolated");
	AST_PUMP: assert property (up > 3'h3 && $past(senseIn.pumpFault, 3) |-> !chargePumpEnable)
		else $error("pump not disabled");
	AST_THERMAL: assert property (up > 3'h3 && $past(senseIn.thermalTrip, 3) |-> !switcherEnable)
		else $error("switching during thermal trip");
	cover property ($rose(supervisorResetOe_n));
	cover property ($rose(diodeFaultLatched));
	cover property ($fell(remote5vEnable));
endmodule // fault_sup_checker
bind regulator_fault_supervisor fault_sup_checker #(.RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)) chk (
	.clk_sys, .reset_n, .senseIn, .remoteIn, .supervisorResetOe_n, .switcherEnable,
	.chargePumpEnable, .remote5vEnable, .ignitionStatusOut, .diodeFaultLatched);

// *** sim/regulator_fault_supervisor_tb.sv ***
// Purpose: directed tests of the supervisor
// Assumes: short soft start and reset delay parameters
// Notes: outputs are read at a falling edge, well after the latency
`timescale 1ns/100ps
module regulator_fault_supervisor_tb;
	import reg_fault_pkg::*;
	logic    clk_sys = 1'b0;
	logic    reset_n = 1'b0;
	sense_s  s = 12'h228;
	remote_s r = 1'b0;
	logic    rOut, rOe_n, swEn, ssAct, cpEn, remEn, locEn, auxEn, ignSt, dFlt, sFlt, pin;
	int      n_errors = 0;
	int      n_tests = 0;
	always #12.5 clk_sys = ~clk_sys;
	regulator_fault_supervisor #(.SOFT_START_CYCLES(20), .RESET_DELAY_CYCLES(10)) dut (
		.clk_sys, .reset_n, .senseIn(s), .remoteIn(r), .supervisorResetIn(pin),
		.supervisorResetOut(rOut), .supervisorResetOe_n(rOe_n), .switcherEnable(swEn),
		.softStartActive(ssAct), .chargePumpEnable(cpEn), .remote5vEnable(remEn),
		.local5vEnable(locEn), .aux3v3Enable(auxEn), .ignitionStatusOut(ignSt),
		.diodeFaultLatched(dFlt), .shortFaultLatched(sFlt));
	reset_pin_model far (.resetOut(rOut), .resetOe_n(rOe_n), .pin(pin));
	task chk(input string m, input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t %s got %b", $time, m, g);
		end
	endtask
	task settle(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task summarize();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk_sys);
		n_errors++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys) s.logicEnable <= 1'b1;
		settle(5);
		chk("ss", ssAct, 1'b1);
		chk("por", rOe_n, 1'b0);
		chk("porp", pin, 1'b0);
		@(posedge clk_sys) s <= s | 12'h1c0;
		// release lands thirteen edges after the drive: three edges of latency, then the ten-cycle delay
		settle(12);
		chk("dly", rOe_n, 1'b0);
		settle(1);
		chk("rel", rOe_n, 1'b1);
		settle(10);
		chk("pin", pin, 1'b1);
		chk("ssend", ssAct, 1'b0);
		chk("loc", locEn & auxEn & swEn & cpEn & remEn, 1'b1);
		@(posedge clk_sys) s.ignitionEnable <= 1'b1;
		settle(5);
		chk("ign", ignSt, 1'b1);
		@(posedge clk_sys) s.logicEnable <= 1'b0;
		settle(5);
		chk("or", rOe_n, 1'b1);
		@(posedge clk_sys) s.ignitionEnable <= 1'b0;
		settle(5);
		chk("ign0", ignSt, 1'b0);
		chk("off", rOe_n, 1'b0);
		chk("offl", locEn, 1'b0);
		@(posedge clk_sys) s.logicEnable <= 1'b1;
		settle(20);
		chk("ssno", ssAct, 1'b0);
		@(posedge clk_sys) s.thermalTrip <= 1'b1;
		settle(5);
		chk("tsw", swEn, 1'b0);
		chk("tpor", rOe_n, 1'b1);
		@(posedge clk_sys) s.thermalTrip <= 1'b0;
		settle(5);
		chk("tre", swEn, 1'b1);
		@(posedge clk_sys) r.remoteShort <= 1'b1;
		settle(5);
		chk("rem", remEn, 1'b0);
		chk("oth", locEn & auxEn & swEn, 1'b1);
		@(posedge clk_sys) r.remoteShort <= 1'b0;
		settle(5);
		chk("rem1", remEn, 1'b1);
		@(posedge clk_sys) s.pumpFault <= 1'b1;
		settle(5);
		chk("cp", cpEn, 1'b0);
		@(posedge clk_sys) s.pumpFault <= 1'b0;
		settle(5);
		chk("cp1", cpEn, 1'b1);
		// six cycles is just under the qualification time
		@(posedge clk_sys) s.switchNodeNeg <= 1'b1;
		repeat (6) @(posedge clk_sys);
		s.switchNodeNeg <= 1'b0;
		settle(5);
		chk("dpul", dFlt, 1'b0);
		@(posedge clk_sys) s.switchNodeNeg <= 1'b1;
		settle(14);
		chk("dset", dFlt & ~swEn, 1'b1);
		@(posedge clk_sys) s.switchNodeNeg <= 1'b0;
		settle(5);
		chk("dhld", dFlt, 1'b1);
		@(posedge clk_sys) s.logicEnable <= 1'b0;
		settle(5);
		@(posedge clk_sys) s.logicEnable <= 1'b1;
		settle(20);
		chk("dclr", dFlt, 1'b0);
		@(posedge clk_sys) s.peakCurrent <= 1'b1;
		settle(5);
		@(posedge clk_sys) s.peakCurrent <= 1'b0;
		settle(5);
		chk("sset", sFlt & ~swEn, 1'b1);
		@(posedge clk_sys) s.supplyOk <= 1'b0;
		settle(5);
		chk("sclr", sFlt, 1'b0);
		@(posedge clk_sys) s.supplyOk <= 1'b1;
		settle(20);
		chk("sre", swEn, 1'b1);
		summarize();
	end
endmodule // regulator_fault_supervisor_tb
